// ---- resp_defs_and_fit.sv ----
// constants of the response formatter and the acceleration code fitter
`timescale 1ns/1ps

// =====================================================================
// shared constants
package resp_defs_pkg;
    // register byte offsets on the register bus
    localparam logic [4:0] NODE_OFS = 5'h00;
    localparam logic [4:0] CFG_OFS = 5'h04;
    localparam logic [4:0] CFG1_OFS = 5'h08;
    localparam logic [4:0] CTRL_OFS = 5'h0C;
    localparam logic [4:0] STAT_OFS = 5'h10;
    localparam logic [4:0] LAST_OFS = 5'h14;
    localparam logic [4:0] CNT_OFS = 5'h18;
    // control and status bit positions
    localparam int CTRL_CHECK_BIT = 0;
    localparam int CTRL_ENH_BIT = 1;
    localparam int STAT_FAULT_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam int CFG_ID_BIT = 7;
    // reset values
    localparam logic [3:0] NODE_RST = 4'h1;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [1:0] CFG1_RST = 2'h0;
    // command codes
    localparam logic [3:0] OP_ACCEL = 4'h2;
    localparam logic [3:0] OP_NI3 = 4'h3;
    localparam logic [3:0] OP_ID = 4'h4;
    localparam logic [3:0] OP_NI5 = 4'h5;
    localparam logic [3:0] OP_NI6 = 4'h6;
    localparam logic [3:0] GLOBAL_NODE = 4'h0;
    // response lengths in data bits
    localparam logic [4:0] LEN_8 = 5'h08;
    localparam logic [4:0] LEN_9 = 5'h09;
    localparam logic [4:0] LEN_CHECK = 5'h0D;
    localparam logic [4:0] LEN_ATTR = 5'h0F;
    localparam logic [4:0] SHORT_MAX = 5'h0F;
    localparam logic [4:0] LONG_BITS = 5'h10;
    // acceleration coding
    localparam logic [9:0] OB_FLIP = 10'h200;
    localparam logic [9:0] ACC_MIN = 10'h001;
    localparam logic [9:0] ACC_ERR = 10'h000;
endpackage

// =====================================================================
// fit the ten-bit code to the response length
module acc_code_fit (
    input wire logic [9:0] acc,
    input wire logic [4:0] len,
    input wire logic err,
    output logic [9:0] code
);
    // drop low bits for eight- and nine-bit lengths, keep zero for sensor error only
    always_comb begin
        code = acc;
        if (len == resp_defs_pkg::LEN_8) begin
            code = {2'h0, acc[9:2]};
        end else if (len == resp_defs_pkg::LEN_9) begin
            code = {1'h0, acc[9:1]};
        end
        if (err) begin
            code = resp_defs_pkg::ACC_ERR;
        end else if (code == resp_defs_pkg::ACC_ERR) begin
            code = resp_defs_pkg::ACC_MIN;
        end
    end
endmodule

// ---- sensor_bus_response_formatter.sv ----
// command decode and response build for the sensor bus node
// =====================================================================
// Summary of operation
// - long accel: node, zero, fault, ten-bit value
// - keep a ten-bit acceleration result
// - fault flag is one on internal error
// - check indicator one while self-test runs
// - attribute bits copied from configuration register
// - pad response to received message length
// - eight- and nine-bit lengths drop low acceleration bits
// - truncated zero becomes code one
// - offset binary, midscale is zero g
// - code one max negative, zero means error
// - ignore codes three, five and six
// - id request in standard and enabled enhanced
// - ignore id request to global node
// - command data bits only feed CRC
// - id request decoded from code four
// - ignore commands for another node number
// - id response revision in bits seven-five
// - id low bits, variable bit from config
// - long responses lead with own node
// - acceleration read decoded from code two
`timescale 1ns/1ps

module sensor_bus_response_formatter #(
    parameter logic [2:0] VERSION_ID = 3'h1, // arbitrary value
    parameter logic [2:0] ID_FIXED_BITS = 3'h5 // arbitrary value
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic accel_valid,
    input wire logic [9:0] accel_raw,
    input wire logic accel_err,
    input wire logic fault,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic cmd_long,
    input wire logic cmd_enhanced,
    input wire logic [4:0] cmd_len,
    input wire logic crc_ok,
    output logic resp_valid,
    output logic [15:0] resp_data,
    output logic [4:0] resp_bits,
    output logic [4:0] resp_fill
);

    // =================================================================
    // state
    typedef struct packed {
        logic wait_n;
        logic [31:0] rdata;
        logic [3:0] node;
        logic [7:0] config_word;
        logic [1:0] attribute_bits;
        logic check_circuit_on;
        logic enh_enable;
        logic [9:0] accel;
        logic accel_bad;
        logic fault;
        logic resp_valid;
        logic [15:0] resp_data;
        logic [4:0] resp_bits;
        logic [4:0] resp_fill;
        logic [15:0] resp_cnt;
    } state_s;

    state_s q;
    state_s d;
    logic [3:0] cmd_op;
    logic [3:0] cmd_node;
    logic addr_ok;
    logic fmt_ok;
    logic hit_acc;
    logic hit_id;
    logic [4:0] dbits;
    logic [9:0] acc_code;
    logic [15:0] acc_word;
    logic [15:0] id_word;
    logic identifier_bit;
    logic [31:0] rd_mux;

    // keep only the low n bits of a response word
    function automatic logic [15:0] keep_low(input logic [15:0] w, input logic [4:0] n);
        logic [15:0] m;
        m = 16'hFFFF;
        if (n < resp_defs_pkg::LONG_BITS) begin
            m = ~(16'hFFFF << n);
        end
        return w & m;
    endfunction

    // =================================================================
    // command decode; data bits 15:8 are not looked at
    assign cmd_op = cmd_word[3:0];
    assign cmd_node = cmd_word[7:4];
    assign addr_ok = (cmd_node == q.node) && (cmd_node != resp_defs_pkg::GLOBAL_NODE);
    assign fmt_ok = !cmd_enhanced || q.enh_enable;
    assign hit_acc = cmd_valid && crc_ok && fmt_ok && addr_ok
        && (cmd_op == resp_defs_pkg::OP_ACCEL);
    assign hit_id = cmd_valid && crc_ok && fmt_ok && addr_ok
        && (cmd_op == resp_defs_pkg::OP_ID);
    assign identifier_bit = q.config_word[resp_defs_pkg::CFG_ID_BIT];

    // data bits carried: sixteen when long, up to fifteen when short
    always_comb begin
        if (cmd_long) begin
            dbits = resp_defs_pkg::LONG_BITS;
        end else if (cmd_len > resp_defs_pkg::SHORT_MAX) begin
            dbits = resp_defs_pkg::SHORT_MAX;
        end else begin
            dbits = cmd_len;
        end
    end

    // truncation and error code of the acceleration value
    acc_code_fit u_fit (
        .acc(q.accel),
        .len(dbits),
        .err(q.accel_bad),
        .code(acc_code)
    );

    // response word layouts
    always_comb begin
        if (cmd_long) begin
            acc_word = {q.node, 1'b0, q.fault, acc_code};
            id_word = {q.node, 4'h0, VERSION_ID, 1'b0, identifier_bit, ID_FIXED_BITS};
        end else begin
            acc_word = {1'b0, q.attribute_bits, q.check_circuit_on, 1'b0, q.fault,
                acc_code};
            id_word = {8'h00, VERSION_ID, 1'b0, identifier_bit, ID_FIXED_BITS};
        end
    end

    // register read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            resp_defs_pkg::NODE_OFS: rd_mux[3:0] = q.node;
            resp_defs_pkg::CFG_OFS: rd_mux[7:0] = q.config_word;
            resp_defs_pkg::CFG1_OFS: rd_mux[1:0] = q.attribute_bits;
            resp_defs_pkg::CTRL_OFS: begin
                rd_mux[resp_defs_pkg::CTRL_CHECK_BIT] = q.check_circuit_on;
                rd_mux[resp_defs_pkg::CTRL_ENH_BIT] = q.enh_enable;
            end
            resp_defs_pkg::STAT_OFS: begin
                rd_mux[resp_defs_pkg::STAT_FAULT_BIT] = q.fault;
                rd_mux[resp_defs_pkg::STAT_ERR_BIT] = q.accel_bad;
            end
            resp_defs_pkg::LAST_OFS: rd_mux[15:0] = q.resp_data;
            resp_defs_pkg::CNT_OFS: rd_mux[15:0] = q.resp_cnt;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // =================================================================
    // next state
    always_comb begin
        d = q;
        d.resp_valid = 1'b0;
        d.fault = fault;
        // bus slave: one wait cycle, then the access completes
        if ((avs_read || avs_write) && q.wait_n) begin
            d.wait_n = 1'b0;
            d.rdata = rd_mux;
        end else if (!q.wait_n) begin
            d.wait_n = 1'b1;
            if (avs_write && avs_byteenable[0]) begin
                unique case (avs_address)
                    resp_defs_pkg::NODE_OFS: d.node = avs_writedata[3:0];
                    resp_defs_pkg::CFG_OFS: d.config_word = avs_writedata[7:0];
                    resp_defs_pkg::CFG1_OFS: d.attribute_bits = avs_writedata[1:0];
                    resp_defs_pkg::CTRL_OFS: begin
                        d.check_circuit_on = avs_writedata[resp_defs_pkg::CTRL_CHECK_BIT];
                        d.enh_enable = avs_writedata[resp_defs_pkg::CTRL_ENH_BIT];
                    end
                    default: d.rdata = q.rdata;
                endcase
            end
        end
        // latch the sample, two's complement to offset binary
        if (accel_valid) begin
            d.accel = accel_raw ^ resp_defs_pkg::OB_FLIP;
            d.accel_bad = accel_err;
        end
        // build a response; anything else leaves state alone
        if (hit_acc || hit_id) begin
            d.resp_valid = 1'b1;
            d.resp_data = keep_low(hit_acc ? acc_word : id_word, dbits);
            d.resp_bits = dbits;
            d.resp_fill = (cmd_len > dbits) ? 5'(cmd_len - dbits) : 5'h00;
            d.resp_cnt = 16'(q.resp_cnt + 16'h0001);
        end
    end

    // register the state
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            q <= '0;
            q.wait_n <= 1'b1;
            q.node <= resp_defs_pkg::NODE_RST;
            q.config_word <= resp_defs_pkg::CFG_RST;
            q.attribute_bits <= resp_defs_pkg::CFG1_RST;
            q.accel <= resp_defs_pkg::OB_FLIP;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.wait_n;
    assign resp_valid = q.resp_valid;
    assign resp_data = q.resp_data;
    assign resp_bits = q.resp_bits;
    assign resp_fill = q.resp_fill;

    // =================================================================
    // checks
    long_accel_layout_a: assert property (@(posedge mclk) disable iff (sys_rst)
        hit_acc && cmd_long |=> resp_valid && resp_data[15:12] == $past(q.node)
        && !resp_data[11] && resp_data[10] == $past(q.fault))
        else $error("long acceleration response layout wrong");

    fault_follow_a: assert property (@(posedge mclk) disable iff (sys_rst)
        fault ##1 hit_acc && cmd_long |=> resp_data[10])
        else $error("fault flag not reported");

    check_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
        hit_acc && !cmd_long && cmd_len >= resp_defs_pkg::LEN_CHECK
        |=> resp_data[12] == $past(q.check_circuit_on))
        else $error("check circuit indicator wrong");

    attr_copy_a: assert property (@(posedge mclk) disable iff (sys_rst)
        hit_acc && !cmd_long && cmd_len >= resp_defs_pkg::LEN_ATTR
        |=> resp_data[14:13] == $past(q.attribute_bits))
        else $error("attribute bits not copied");

    fill_length_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (hit_acc || hit_id) |=> resp_bits + resp_fill == $past(cmd_len)
        || (resp_bits > $past(cmd_len) && resp_fill == 5'h00))
        else $error("response length does not match command");

    trunc_eight_a: assert property (@(posedge mclk) disable iff (sys_rst)
        hit_acc && !cmd_long && cmd_len == resp_defs_pkg::LEN_8 && !q.accel_bad
        && q.accel[9:2] != 8'h00 |=> resp_data == {8'h00, $past(q.accel[9:2])})
        else $error("eight-bit truncation wrong");

    min_code_a: assert property (@(posedge mclk) disable iff (sys_rst)
        hit_acc && !q.accel_bad |=> resp_data[9:0] != resp_defs_pkg::ACC_ERR)
        else $error("zero code sent without sensor error");

    offset_code_a: assert property (@(posedge mclk) disable iff (sys_rst)
        accel_valid && !accel_err && accel_raw == 10'h000 ##1 hit_acc && cmd_long
        |=> resp_data[9:0] == resp_defs_pkg::OB_FLIP)
        else $error("zero g does not code as midscale");

    ignore_codes_a: assert property (@(posedge mclk) disable iff (sys_rst)
        cmd_valid && (cmd_op == resp_defs_pkg::OP_NI3 || cmd_op == resp_defs_pkg::OP_NI5
        || cmd_op == resp_defs_pkg::OP_NI6) |=> !resp_valid && $stable(q.resp_cnt))
        else $error("unimplemented code answered");

    id_global_a: assert property (@(posedge mclk) disable iff (sys_rst)
        cmd_valid && cmd_node == resp_defs_pkg::GLOBAL_NODE |=> !resp_valid)
        else $error("global node answered");

    node_match_a: assert property (@(posedge mclk) disable iff (sys_rst)
        cmd_valid && cmd_node != q.node |=> !resp_valid && $stable(q.resp_data))
        else $error("command for another node answered");

    id_layout_a: assert property (@(posedge mclk) disable iff (sys_rst)
        hit_id && cmd_long |=> resp_data[7:5] == VERSION_ID && resp_data[11:8] == 4'h0
        && resp_data[3] == $past(q.config_word[resp_defs_pkg::CFG_ID_BIT]))
        else $error("identification response layout wrong");

    // stored sample is the raw value with its sign bit flipped
    accel_store_a: assert property (@(posedge mclk) disable iff (sys_rst)
        accel_valid |=> q.accel == ($past(accel_raw) ^ resp_defs_pkg::OB_FLIP))
        else $error("acceleration sample not stored as offset binary");

    // fault flag follows its input one cycle later
    fault_reg_a: assert property (@(posedge mclk) disable iff (sys_rst)
        1'b1 |=> q.fault == $past(fault))
        else $error("fault flag not registered");

    // nine-bit responses keep the upper nine bits
    trunc_nine_a: assert property (@(posedge mclk) disable iff (sys_rst)
        hit_acc && !cmd_long && cmd_len == resp_defs_pkg::LEN_9 && !q.accel_bad
        && q.accel[9:1] != 9'h000 |=> resp_data == {7'h00, $past(q.accel[9:1])})
        else $error("nine-bit truncation wrong");

    // a sensor error always codes as zero
    err_code_a: assert property (@(posedge mclk) disable iff (sys_rst)
        hit_acc && q.accel_bad |=> resp_data[9:0] == resp_defs_pkg::ACC_ERR)
        else $error("sensor error not coded as zero");

    // enhanced formats only while enabled
    enh_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
        cmd_valid && cmd_enhanced && !q.enh_enable |=> !resp_valid)
        else $error("disabled enhanced format answered");

    // short identification response has a clear upper byte
    id_short_a: assert property (@(posedge mclk) disable iff (sys_rst)
        hit_id && !cmd_long |=> resp_data[15:8] == 8'h00
        && resp_data[3] == $past(identifier_bit))
        else $error("short identification response layout wrong");

    // long identification response leads with the own node
    id_node_a: assert property (@(posedge mclk) disable iff (sys_rst)
        hit_id && cmd_long |=> resp_data[15:12] == $past(q.node))
        else $error("identification response node wrong");

    // a bad check sum leaves everything alone
    crc_drop_a: assert property (@(posedge mclk) disable iff (sys_rst)
        cmd_valid && !crc_ok |=> !resp_valid && $stable(q.resp_cnt))
        else $error("command with bad check answered");

endmodule

// ---- ctl_model.sv ----
// behavioural model of the bus controller that issues addressed commands
`timescale 1ns/1ps

// =====================================================================
// command source
module ctl_model (
    input wire logic mclk,
    output logic cmd_valid,
    output logic [15:0] cmd_word,
    output logic cmd_long,
    output logic cmd_enhanced,
    output logic [4:0] cmd_len,
    output logic crc_ok
);
    // idle levels before the first command
    initial begin
        cmd_valid = 1'b0;
        cmd_word = 16'h0000;
        cmd_long = 1'b0;
        cmd_enhanced = 1'b0;
        cmd_len = 5'h08;
        crc_ok = 1'b0;
    end

    // one command for one cycle, then inverted leftovers on the lines except the length
    task automatic send(input logic [3:0] node, input logic [3:0] op, input logic lg,
        input logic en, input logic [4:0] ln, input logic ok);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_word <= {8'hA5, node, op};
        cmd_long <= lg;
        cmd_enhanced <= en;
        cmd_len <= ln;
        crc_ok <= ok;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_word <= ~{8'hA5, node, op};
        cmd_long <= ~lg;
        cmd_enhanced <= ~en;
        crc_ok <= ~ok;
    endtask
endmodule

// ---- sensor_bus_response_formatter_tb_top.sv ----
// self-checking bench of the sensor bus response formatter
`timescale 1ns/1ps

// =====================================================================
// bench top
module sensor_bus_response_formatter_tb_top;
    localparam logic [2:0] VID = 3'h3; // arbitrary value
    localparam logic [2:0] FIX = 3'h6; // arbitrary value
    logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic accel_valid, accel_err, fault, resp_valid;
    logic cmd_valid, cmd_long, cmd_enhanced, crc_ok;
    logic [4:0] avs_address, cmd_len, resp_bits, resp_fill;
    logic [31:0] avs_writedata, avs_readdata, rd_val, cnt_val;
    logic [3:0] avs_byteenable;
    logic [9:0] accel_raw;
    logic [15:0] cmd_word, resp_data;
    int failures, n_tests;

    sensor_bus_response_formatter #(.VERSION_ID(VID), .ID_FIXED_BITS(FIX)) u_dut (
        .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .accel_valid(accel_valid),
        .accel_raw(accel_raw), .accel_err(accel_err), .fault(fault),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_long(cmd_long),
        .cmd_enhanced(cmd_enhanced), .cmd_len(cmd_len), .crc_ok(crc_ok),
        .resp_valid(resp_valid), .resp_data(resp_data), .resp_bits(resp_bits),
        .resp_fill(resp_fill));

    ctl_model u_ctl (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .cmd_long(cmd_long), .cmd_enhanced(cmd_enhanced), .cmd_len(cmd_len),
        .crc_ok(crc_ok));

    // clock of 50 ns
    always #25 mclk = ~mclk;

    // =================================================================
    // shared tasks
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one register access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd_val = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk({31'h0, avs_waitrequest}, 32'h0);
    endtask

    // new acceleration sample with fault level
    task automatic sample(input logic [9:0] r, input logic e, input logic f);
        @(posedge mclk);
        accel_valid <= 1'b1;
        accel_raw <= r;
        accel_err <= e;
        fault <= f;
        @(posedge mclk);
        accel_valid <= 1'b0;
        @(posedge mclk);
    endtask

    // command and judgement of the answer one cycle later
    task automatic cmd(input logic [3:0] nd, input logic [3:0] op, input logic [4:0] ln,
        input logic [1:0] fmt, input logic ok, input logic v, input logic [15:0] d,
        input logic [4:0] b);
        u_ctl.send(nd, op, fmt[1], fmt[0], ln, ok);
        #1;
        chk({31'h0, resp_valid}, {31'h0, v});
        if (v) begin
            chk({16'h0, resp_data}, {16'h0, d});
            chk({27'h0, resp_bits}, {27'h0, b});
            chk({27'h0, resp_fill}, {27'h0, (ln > b) ? ln - b : 5'h00});
        end
    endtask

    // =================================================================
    // scenarios
    task automatic t_regs;
        bus(1'b0, resp_defs_pkg::NODE_OFS, 32'h0);
        chk(rd_val, 32'h1);
        bus(1'b0, 5'h1C, 32'h0);
        chk(rd_val, 32'h0);
        bus(1'b1, resp_defs_pkg::NODE_OFS, 32'h9);
        bus(1'b1, resp_defs_pkg::CFG1_OFS, 32'h3);
        bus(1'b1, resp_defs_pkg::CFG_OFS, 32'h80);
        bus(1'b1, resp_defs_pkg::CTRL_OFS, 32'h1);
        bus(1'b0, resp_defs_pkg::NODE_OFS, 32'h0);
        chk(rd_val, 32'h9);
    endtask

    task automatic t_accel;
        sample(10'h1FF, 1'b0, 1'b1);
        cmd(4'h9, 4'h2, 5'h10, 2'b10, 1'b1, 1'b1, 16'h97FF, 5'h10);
        sample(10'h201, 1'b0, 1'b1);
        cmd(4'h9, 4'h2, 5'h08, 2'b00, 1'b1, 1'b1, 16'h0001, 5'h08);
        cmd(4'h9, 4'h2, 5'h09, 2'b00, 1'b1, 1'b1, 16'h0001, 5'h09);
        sample(10'h000, 1'b0, 1'b1);
        cmd(4'h9, 4'h2, 5'h09, 2'b00, 1'b1, 1'b1, 16'h0100, 5'h09);
        cmd(4'h9, 4'h2, 5'h0D, 2'b00, 1'b1, 1'b1, 16'h1600, 5'h0D);
        cmd(4'h9, 4'h2, 5'h14, 2'b00, 1'b1, 1'b1, 16'h7600, 5'h0F);
        sample(10'h155, 1'b1, 1'b0);
        cmd(4'h9, 4'h2, 5'h10, 2'b10, 1'b1, 1'b1, 16'h9000, 5'h10);
    endtask

    task automatic t_id;
        cmd(4'h9, 4'h4, 5'h12, 2'b10, 1'b1, 1'b1, {8'h90, VID, 2'b01, FIX}, 5'h10);
        cmd(4'h9, 4'h4, 5'h08, 2'b00, 1'b1, 1'b1, {8'h00, VID, 2'b01, FIX}, 5'h08);
    endtask

    task automatic t_ignore;
        logic [3:0] ops [3];
        ops = '{4'h3, 4'h5, 4'h6};
        bus(1'b0, resp_defs_pkg::CNT_OFS, 32'h0);
        cnt_val = rd_val;
        foreach (ops[i]) begin
            cmd(4'h9, ops[i], 5'h10, 2'b10, 1'b1, 1'b0, 16'h0, 5'h0);
        end
        cmd(4'h0, 4'h4, 5'h10, 2'b10, 1'b1, 1'b0, 16'h0, 5'h0);
        cmd(4'h3, 4'h2, 5'h10, 2'b10, 1'b1, 1'b0, 16'h0, 5'h0);
        cmd(4'h9, 4'h4, 5'h10, 2'b11, 1'b1, 1'b0, 16'h0, 5'h0);
        cmd(4'h9, 4'h2, 5'h10, 2'b10, 1'b0, 1'b0, 16'h0, 5'h0);
        bus(1'b0, resp_defs_pkg::CNT_OFS, 32'h0);
        chk(rd_val, cnt_val);
        bus(1'b1, resp_defs_pkg::CTRL_OFS, 32'h3);
        cmd(4'h9, 4'h4, 5'h10, 2'b11, 1'b1, 1'b1, {8'h90, VID, 2'b01, FIX}, 5'h10);
    endtask

    // =================================================================
    // main sequence
    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        accel_valid = 1'b0;
        accel_raw = 10'h000;
        accel_err = 1'b0;
        fault = 1'b0;
        failures = 0;
        n_tests = 0;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs();
        t_accel();
        t_id();
        t_ignore();
        close_out();
    end

    // watchdog against a hang
    initial begin
        #100000;
        failures++;
        close_out();
    end
endmodule
